// *** rtl/wit_pkg.sv ***
package wit_pkg;
	localparam int ADDR_W = 16;
	localparam int PRESC_W = 17;
	localparam int CNT_W = 8;
	localparam int EV_W = 2;
	localparam logic [15:0] CTRL_OFS = 16'hffbc;
	localparam logic [15:0] ISTS_OFS = 16'hffc0;
	localparam logic [15:0] IMSK_OFS = 16'hffc4;
	localparam logic [7:0] CTRL_RST = 8'h18;
	localparam logic [7:0] WR_KEY = 8'h5a;
	localparam logic [1:0] EV_RST = 2'h0;
	localparam logic [7:0] CNT_RST = 8'h00;
	localparam logic [7:0] CNT_MAX = 8'hff;
	localparam logic [16:0] PRESC_RST = 17'h00000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int EV_IVL = 0;
	localparam int EV_WDT = 1;
	// Divide ratio minus one for each clock-select code.
	localparam logic [16:0] DIV_MASK [8] = '{
		17'h00001, 17'h0003f, 17'h0007f, 17'h001ff,
		17'h007ff, 17'h01fff, 17'h07fff, 17'h1ffff
	};

	typedef struct packed {
		logic ovf;
		logic mode;
		logic ten;
		logic [1:0] rsv;
		logic [2:0] cks;
	} wit_ctrl_t;

	typedef struct packed {
		logic wdt;
		logic ivl;
	} wit_ev_t;
endpackage

// *** rtl/wit_ctrl.sv ***
`timescale 1ns/100ps
// Function
// - clock select picks phi/2 up to phi/131072
// - period is full pass from zero
// - enable low holds counter at zero
// - interval mode overflow raises interval interrupt
// - watchdog mode overflow drives overflow output
// - register layout, reset value 0x18
// - one address, separate write and read paths
// - overflow flag set on wrap, interval mode
// - flag cleared by read then write 0
module wit_ctrl (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [15:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [15:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq,
	output logic interval_interrupt_request,
	output logic watchdog_overflow_output
);
	logic aw_hold_ff, nxt_aw_hold;
	logic w_hold_ff, nxt_w_hold;
	logic [15:0] awaddr_ff, nxt_awaddr;
	logic [31:0] wdata_ff, nxt_wdata;
	logic [3:0] wstrb_ff, nxt_wstrb;
	logic awready_ff, nxt_awready;
	logic wready_ff, nxt_wready;
	logic bvalid_ff, nxt_bvalid;
	logic [1:0] bresp_ff, nxt_bresp;
	logic arready_ff, nxt_arready;
	logic rvalid_ff, nxt_rvalid;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [1:0] rresp_ff, nxt_rresp;
	logic wr_go, rd_go, ctrl_wr, ctrl_rd_arm;
	logic sts_wr, msk_wr, key_ok;

	wit_pkg::wit_ctrl_t ctrl_ff, nxt_ctrl;
	logic [7:0] cnt_ff, nxt_cnt;
	logic [16:0] presc_ff, nxt_presc;
	logic armed_ff, nxt_armed;
	wit_pkg::wit_ev_t sts_ff, nxt_sts;
	wit_pkg::wit_ev_t msk_ff, nxt_msk;
	wit_pkg::wit_ev_t ev;
	logic irq_ff, nxt_irq;
	logic ivl_ff, nxt_ivl;
	logic wdt_ff, nxt_wdt;
	logic tick, wrap;
	logic [16:0] dmask;

	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign irq = irq_ff;
	assign interval_interrupt_request = ivl_ff;
	assign watchdog_overflow_output = wdt_ff;

	// Bus side: address and data are latched separately, then paired.
	always_comb begin
		nxt_aw_hold = aw_hold_ff;
		nxt_w_hold = w_hold_ff;
		nxt_awaddr = awaddr_ff;
		nxt_wdata = wdata_ff;
		nxt_wstrb = wstrb_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp = bresp_ff;
		nxt_rvalid = rvalid_ff;
		nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;
		ctrl_wr = 1'b0;
		sts_wr = 1'b0;
		msk_wr = 1'b0;
		ctrl_rd_arm = 1'b0;
		key_ok = wdata_ff[15:8] == wit_pkg::WR_KEY
			&& wstrb_ff[1:0] == 2'h3;
		if (s_axi_awvalid && awready_ff) begin
			nxt_aw_hold = 1'b1;
			nxt_awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_ff) begin
			nxt_w_hold = 1'b1;
			nxt_wdata = s_axi_wdata;
			nxt_wstrb = s_axi_wstrb;
		end
		wr_go = aw_hold_ff && w_hold_ff && !bvalid_ff;
		if (wr_go) begin
			nxt_aw_hold = 1'b0;
			nxt_w_hold = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp = wit_pkg::RESP_OKAY;
			// Same address as the read path, own decode.
			if (awaddr_ff[15:2] == wit_pkg::CTRL_OFS[15:2]) begin
				// An unkeyed store is refused with an error.
				ctrl_wr = key_ok;
				if (!key_ok) begin
					nxt_bresp = wit_pkg::RESP_SLVERR;
				end
			end else if (awaddr_ff[15:2] == wit_pkg::ISTS_OFS[15:2]) begin
				sts_wr = wstrb_ff[0];
			end else if (awaddr_ff[15:2] == wit_pkg::IMSK_OFS[15:2]) begin
				msk_wr = wstrb_ff[0];
			end else begin
				nxt_bresp = wit_pkg::RESP_SLVERR;
			end
		end
		if (bvalid_ff && s_axi_bready) begin
			nxt_bvalid = 1'b0;
		end
		nxt_awready = !nxt_aw_hold && !nxt_bvalid;
		nxt_wready = !nxt_w_hold && !nxt_bvalid;
		rd_go = s_axi_arvalid && arready_ff;
		if (rd_go) begin
			nxt_rvalid = 1'b1;
			nxt_rresp = wit_pkg::RESP_OKAY;
			nxt_rdata = 32'h00000000;
			if (s_axi_araddr[15:2] == wit_pkg::CTRL_OFS[15:2]) begin
				nxt_rdata[7:0] = ctrl_ff;
				ctrl_rd_arm = ctrl_ff.ovf;
			end else if (s_axi_araddr[15:2] == wit_pkg::ISTS_OFS[15:2]) begin
				nxt_rdata[1:0] = sts_ff;
			end else if (s_axi_araddr[15:2] == wit_pkg::IMSK_OFS[15:2]) begin
				nxt_rdata[1:0] = msk_ff;
			end else begin
				nxt_rresp = wit_pkg::RESP_SLVERR;
			end
		end
		if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid = 1'b0;
		end
		nxt_arready = !nxt_rvalid;
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff <= 1'b0;
			awaddr_ff <= 16'h0000;
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
			awready_ff <= 1'b0;
			wready_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= wit_pkg::RESP_OKAY;
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= wit_pkg::RESP_OKAY;
		end else begin
			aw_hold_ff <= nxt_aw_hold;
			w_hold_ff <= nxt_w_hold;
			awaddr_ff <= nxt_awaddr;
			wdata_ff <= nxt_wdata;
			wstrb_ff <= nxt_wstrb;
			awready_ff <= nxt_awready;
			wready_ff <= nxt_wready;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			arready_ff <= nxt_arready;
			rvalid_ff <= nxt_rvalid;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
		end
	end

	// Timer core. The prescaler runs free so a selected tap needs no
	// warm-up, at the cost of a short first count after enabling.
	always_comb begin
		dmask = wit_pkg::DIV_MASK[ctrl_ff.cks];
		tick = (presc_ff & dmask) == dmask;
		nxt_presc = presc_ff + 17'h00001;
		wrap = ctrl_ff.ten && tick && cnt_ff == wit_pkg::CNT_MAX;
		nxt_cnt = cnt_ff;
		if (!ctrl_ff.ten) begin
			nxt_cnt = wit_pkg::CNT_RST;
		end else if (tick) begin
			nxt_cnt = cnt_ff + 8'h01;
		end
		ev.ivl = wrap && !ctrl_ff.mode;
		ev.wdt = wrap && ctrl_ff.mode;
		nxt_ctrl = ctrl_ff;
		nxt_armed = armed_ff || ctrl_rd_arm;
		if (ctrl_wr) begin
			nxt_ctrl.mode = wdata_ff[6];
			nxt_ctrl.ten = wdata_ff[5];
			nxt_ctrl.cks = wdata_ff[2:0];
			// Only a zero after a read that saw the flag clears it.
			if (!wdata_ff[7] && armed_ff) begin
				nxt_ctrl.ovf = 1'b0;
			end
			nxt_armed = 1'b0;
		end
		if (ev.ivl) begin
			nxt_ctrl.ovf = 1'b1;
		end
		nxt_sts = sts_ff;
		if (sts_wr) begin
			nxt_sts = sts_ff & ~wit_pkg::wit_ev_t'(wdata_ff[1:0]);
		end
		nxt_sts = nxt_sts | ev;
		nxt_msk = msk_ff;
		if (msk_wr) begin
			nxt_msk = wit_pkg::wit_ev_t'(wdata_ff[1:0]);
		end
		nxt_irq = |(nxt_sts & nxt_msk);
		nxt_ivl = nxt_ctrl.ovf && !nxt_ctrl.mode;
		nxt_wdt = ev.wdt;
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ctrl_ff <= wit_pkg::wit_ctrl_t'(wit_pkg::CTRL_RST);
			cnt_ff <= wit_pkg::CNT_RST;
			presc_ff <= wit_pkg::PRESC_RST;
			armed_ff <= 1'b0;
			sts_ff <= wit_pkg::EV_RST;
			msk_ff <= wit_pkg::EV_RST;
			irq_ff <= 1'b0;
			ivl_ff <= 1'b0;
			wdt_ff <= 1'b0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			cnt_ff <= nxt_cnt;
			presc_ff <= nxt_presc;
			armed_ff <= nxt_armed;
			sts_ff <= nxt_sts;
			msk_ff <= nxt_msk;
			irq_ff <= nxt_irq;
			ivl_ff <= nxt_ivl;
			wdt_ff <= nxt_wdt;
		end
	end

	// A control write may move the tap, so those cycles are not judged.
	property p_div2_tick;
		@(posedge ref_clk) disable iff (reset)
		ctrl_ff.cks == 3'h0 && !ctrl_wr |=> tick == !$past(tick);
	endproperty
	a_div2_tick: assert property (p_div2_tick)
		else $error("Divide-by-2 tap not alternating.");

	property p_step;
		@(posedge ref_clk) disable iff (reset)
		ctrl_ff.ten && tick && !ctrl_wr
			|=> cnt_ff == 8'($past(cnt_ff) + 8'h01);
	endproperty
	a_step: assert property (p_step)
		else $error("Counter did not step on tick.");

	property p_hold_zero;
		@(posedge ref_clk) disable iff (reset)
		!ctrl_ff.ten |=> cnt_ff == 8'h00;
	endproperty
	a_hold_zero: assert property (p_hold_zero)
		else $error("Counter not held at zero.");

	property p_ivl_req;
		@(posedge ref_clk) disable iff (reset)
		wrap && !ctrl_ff.mode |=> interval_interrupt_request
			&& !watchdog_overflow_output;
	endproperty
	a_ivl_req: assert property (p_ivl_req)
		else $error("Interval request missing after overflow.");

	property p_wdt_out;
		@(posedge ref_clk) disable iff (reset)
		wrap && ctrl_ff.mode |=> watchdog_overflow_output
			##1 !watchdog_overflow_output;
	endproperty
	a_wdt_out: assert property (p_wdt_out)
		else $error("Watchdog output pulse wrong.");

	property p_rsv_read;
		@(posedge ref_clk) disable iff (reset)
		rd_go && s_axi_araddr[15:2] == wit_pkg::CTRL_OFS[15:2]
			|=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000
			&& s_axi_rdata[4:3] == 2'h3;
	endproperty
	a_rsv_read: assert property (p_rsv_read)
		else $error("Control read value malformed.");

	property p_ovf_set;
		@(posedge ref_clk) disable iff (reset)
		wrap && !ctrl_ff.mode |=> ctrl_ff.ovf;
	endproperty
	a_ovf_set: assert property (p_ovf_set)
		else $error("Overflow flag not set on wrap.");

	property p_ovf_keep;
		@(posedge ref_clk) disable iff (reset)
		ctrl_ff.ovf && !(ctrl_wr && armed_ff && !wdata_ff[7])
			|=> ctrl_ff.ovf;
	endproperty
	a_ovf_keep: assert property (p_ovf_keep)
		else $error("Overflow flag cleared without read first.");

	property p_bad_key;
		@(posedge ref_clk) disable iff (reset)
		wr_go && awaddr_ff[15:2] == wit_pkg::CTRL_OFS[15:2] && !key_ok
			|=> s_axi_bresp == wit_pkg::RESP_SLVERR
			&& ctrl_ff.cks == $past(ctrl_ff.cks);
	endproperty
	a_bad_key: assert property (p_bad_key)
		else $error("Unkeyed control write took effect.");
endmodule

// *** verif/tb.sv ***
`timescale 1ns/100ps
module tb;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [15:0] s_axi_awaddr = 16'h0000;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [15:0] s_axi_araddr = 16'h0000;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	logic irq;
	logic interval_interrupt_request;
	logic watchdog_overflow_output;
	int err_total = 0;
	int n_compared = 0;

	wit_ctrl i_dut (.ref_clk, .reset, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq,
		.interval_interrupt_request, .watchdog_overflow_output);

	always #20 ref_clk = ~ref_clk;

	task automatic chk(input string nm, input logic [31:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Address and data are held until each channel is taken on its own edge.
	task automatic wr(input logic [15:0] a, input logic [31:0] d,
			output logic [1:0] r);
		int t;
		t = 0;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			t++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && t < 100);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		chk("write answered", t < 100, 1'b1);
	endtask

	task automatic rd(input logic [15:0] a, output logic [31:0] d,
			output logic [1:0] r);
		int t;
		t = 0;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			t++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && t < 100);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		chk("read answered", t < 100, 1'b1);
	endtask

	// Control writes carry the guard key in the second byte lane.
	task automatic wctl(input logic [7:0] v, input logic [1:0] er);
		logic [1:0] r;
		wr(wit_pkg::CTRL_OFS, {16'h0000, wit_pkg::WR_KEY, v}, r);
		chk("ctrl write resp", r, er);
	endtask

	task automatic rchk(input logic [15:0] a, input logic [31:0] ed,
			input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk("read data", d, ed);
		chk("read resp", r, er);
	endtask

	task automatic wait_ev(input logic wdt, input int lim, output int n);
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (!(wdt ? watchdog_overflow_output
			: interval_interrupt_request) && n < lim);
	endtask

	task automatic t_regs();
		logic [1:0] r;
		rchk(wit_pkg::CTRL_OFS, 32'h00000018, wit_pkg::RESP_OKAY);
		rchk(wit_pkg::ISTS_OFS, 32'h00000000, wit_pkg::RESP_OKAY);
		rchk(16'hffd0, 32'h00000000, wit_pkg::RESP_SLVERR);
		wr(wit_pkg::CTRL_OFS, 32'h0000002f, r);
		chk("unkeyed resp", r, wit_pkg::RESP_SLVERR);
		rchk(wit_pkg::CTRL_OFS, 32'h00000018, wit_pkg::RESP_OKAY);
		for (int i = 0; i < 8; i++) begin
			wctl(8'(i), wit_pkg::RESP_OKAY);
			rchk(wit_pkg::CTRL_OFS, 32'(8'h18 | i), wit_pkg::RESP_OKAY);
		end
	endtask

	task automatic t_interval();
		int n;
		logic [1:0] r;
		wr(wit_pkg::IMSK_OFS, 32'h00000003, r);
		wctl(8'h20, wit_pkg::RESP_OKAY);
		wait_ev(1'b0, 700, n);
		// Phi/2 from zero: 256 ticks of two cycles each, plus a few of latency.
		chk("phi2 period", n >= 508 && n <= 520, 1'b1);
		chk("ivl req", interval_interrupt_request, 1'b1);
		chk("wdt out", watchdog_overflow_output, 1'b0);
		rchk(wit_pkg::CTRL_OFS, 32'h000000b8, wit_pkg::RESP_OKAY);
		wctl(8'ha0, wit_pkg::RESP_OKAY);
		wctl(8'h20, wit_pkg::RESP_OKAY);
		chk("flag kept", interval_interrupt_request, 1'b1);
		rchk(wit_pkg::CTRL_OFS, 32'h000000b8, wit_pkg::RESP_OKAY);
		wctl(8'h20, wit_pkg::RESP_OKAY);
		rchk(wit_pkg::CTRL_OFS, 32'h00000038, wit_pkg::RESP_OKAY);
		chk("ivl cleared", interval_interrupt_request, 1'b0);
		chk("irq set", irq, 1'b1);
		wr(wit_pkg::IMSK_OFS, 32'h00000000, r);
		chk("mask resp", r, wit_pkg::RESP_OKAY);
		chk("irq masked", irq, 1'b0);
		wr(wit_pkg::ISTS_OFS, 32'h00000001, r);
		rchk(wit_pkg::ISTS_OFS, 32'h00000000, wit_pkg::RESP_OKAY);
	endtask

	task automatic t_stop();
		wctl(8'h00, wit_pkg::RESP_OKAY);
		repeat (700) @(posedge ref_clk);
		chk("halted", interval_interrupt_request, 1'b0);
		rchk(wit_pkg::CTRL_OFS, 32'h00000018, wit_pkg::RESP_OKAY);
	endtask

	task automatic t_watchdog();
		int n;
		logic [1:0] r;
		wr(wit_pkg::IMSK_OFS, 32'h00000003, r);
		wctl(8'h61, wit_pkg::RESP_OKAY);
		wait_ev(1'b1, 17000, n);
		// Phi/64: 256 ticks of 64 cycles; the free prescaler cuts up to 64 off the first.
		chk("phi64 period", n >= 16320 && n <= 16460, 1'b1);
		@(posedge ref_clk);
		chk("pulse ends", watchdog_overflow_output, 1'b0);
		chk("ivl quiet", interval_interrupt_request, 1'b0);
		chk("irq wdt", irq, 1'b1);
		rchk(wit_pkg::CTRL_OFS, 32'h00000079, wit_pkg::RESP_OKAY);
		rchk(wit_pkg::ISTS_OFS, 32'h00000002, wit_pkg::RESP_OKAY);
	endtask

	initial begin
		#(40 * 60000);
		err_total++;
		summarize();
	end

	initial begin
		repeat (20) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (2) @(posedge ref_clk);
		t_regs();
		t_interval();
		t_stop();
		t_watchdog();
		summarize();
	end
endmodule
